// >>> rtl/mrsc_top.sv
// Modbus RTU slave front end with switch-set address, rate and parity
`timescale 1ns/1ps
`default_nettype none
module mrsc_top #(
  parameter int BUF_DEPTH = mrsc_pkg::BUF_DEPTH
) (
  input  wire logic        aclk,          // Clock, 25 MHz
  input  wire logic        aresetn,       // Sync reset, active low
  input  wire logic [11:0] s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [11:0] s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic [7:0]  addr_sw,       // Station address switches
  input  wire logic [1:0]  rate_sw,       // Bit rate switches
  input  wire logic        parity_sw,     // Even parity when high
  input  wire logic        rs485_rx,      // Line receive data
  output logic             rs485_tx,      // Line transmit data
  output logic             rs485_de       // Line driver enable
);
  localparam int AW = $clog2(BUF_DEPTH);

  typedef enum logic [2:0] {
    FR_RECV  = 3'b001,
    FR_HOLD  = 3'b010,
    FR_REPLY = 3'b100
  } mrsc_fr_e;

  mrsc_pkg::mrsc_cfg_s  cfg;
  mrsc_pkg::mrsc_byte_s rx_byte;
  mrsc_fr_e             state;
  logic [7:0]           station;
  logic                 online;
  logic                 nonstd;
  logic                 rx_busy;
  logic [7:0]           rx_mem [BUF_DEPTH];
  logic [7:0]           tx_mem [BUF_DEPTH];
  logic [AW:0]          rx_len;
  logic [AW:0]          frame_len;
  logic [7:0]           first_byte;
  logic [15:0]          rx_crc;
  logic                 rx_bad;
  logic [15:0]          gap_cyc;
  logic [5:0]           gap_bits;
  logic                 frame_end;
  logic                 frame_ok;
  logic [7:0]           tx_len;
  logic [AW:0]          tx_idx;
  logic [15:0]          tx_crc;
  logic [1:0]           crc_left;
  logic                 tx_valid;
  logic [7:0]           tx_data;
  logic                 tx_ready;
  logic [15:0]          cnt_good;
  logic [15:0]          cnt_drop;
  logic                 aw_hold;
  logic                 w_hold;
  logic [11:0]          aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 do_write;
  logic                 do_release;
  logic                 do_send;
  mrsc_pkg::mrsc_reg_e  wr_reg;
  mrsc_pkg::mrsc_reg_e  rd_reg;

  // Switch sampling into registered configuration
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      station <= mrsc_pkg::ADDR_OFFLINE;
      online  <= 1'b0;
      nonstd  <= 1'b0;
      cfg     <= '{bit_cycles: mrsc_pkg::bit_cycles(2'h0), parity_en: 1'b0};
    end
    else
    begin
      station       <= addr_sw;
      online        <= (addr_sw != mrsc_pkg::ADDR_OFFLINE);
      nonstd        <= (addr_sw > mrsc_pkg::STD_ADDR_MAX);
      cfg.bit_cycles <= mrsc_pkg::bit_cycles(rate_sw);
      cfg.parity_en <= parity_sw;
    end
  end

  mrsc_rx u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (cfg),
    .rxd     (rs485_rx),
    .rx_byte (rx_byte),
    .busy    (rx_busy)
  );

  // Silence of 3.5 characters closes an RTU frame
  assign frame_end = (gap_cyc == cfg.bit_cycles - 16'h0001)
                   && (gap_bits == 6'(mrsc_pkg::FRAME_GAP_BITS - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_cyc  <= 16'h0000;
      gap_bits <= 6'(mrsc_pkg::FRAME_GAP_BITS);
    end
    else if (rx_busy || !rs485_rx || rx_byte.valid)
    begin
      gap_cyc  <= 16'h0000;
      gap_bits <= 6'h00;
    end
    else if (gap_bits != 6'(mrsc_pkg::FRAME_GAP_BITS))
    begin
      if (gap_cyc == cfg.bit_cycles - 16'h0001)
      begin
        gap_cyc  <= 16'h0000;
        gap_bits <= gap_bits + 6'h01;
      end
      else
        gap_cyc <= gap_cyc + 16'h0001;
    end
  end

  assign frame_ok = !rx_bad && (rx_len >= (AW + 1)'(mrsc_pkg::MIN_FRAME_LEN))
                  && (rx_crc == mrsc_pkg::CRC_GOOD)
                  && online && (first_byte == station);

  // Frame collection, echo of own reply is ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_len     <= '0;
      rx_crc     <= mrsc_pkg::CRC_INIT;
      rx_bad     <= 1'b0;
      first_byte <= 8'h00;
    end
    else if (frame_end || state != FR_RECV)
    begin
      rx_len <= '0;
      rx_crc <= mrsc_pkg::CRC_INIT;
      rx_bad <= 1'b0;
    end
    else if (rx_byte.valid)
    begin
      if (rx_len != (AW + 1)'(BUF_DEPTH))
      begin
        rx_mem[rx_len[AW-1:0]] <= rx_byte.data;
        rx_len <= rx_len + (AW + 1)'(1);
      end
      if (rx_len == '0)
        first_byte <= rx_byte.data;
      rx_crc <= mrsc_pkg::crc16_step(rx_crc, rx_byte.data);
      rx_bad <= rx_bad | rx_byte.err | (rx_len == (AW + 1)'(BUF_DEPTH));
    end
  end

  // Frame handling: receive, hold for software, send reply
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state     <= FR_RECV;
      frame_len <= '0;
      cnt_good  <= 16'h0000;
      cnt_drop  <= 16'h0000;
    end
    else
    begin
      case (state)
        FR_RECV:
          if (frame_end && rx_len != '0)
          begin
            if (frame_ok)
            begin
              state     <= FR_HOLD;
              frame_len <= rx_len;
              cnt_good  <= cnt_good + 16'h0001;
            end
            else
              cnt_drop <= cnt_drop + 16'h0001;
          end
        FR_HOLD:
          if (do_send && online)
            state <= FR_REPLY;
          else if (do_release || !online)
            state <= FR_RECV;
        FR_REPLY:
          if (!online || (crc_left == 2'h0 && tx_idx == (AW + 1)'(tx_len)
                          && tx_ready && !tx_valid))
            state <= FR_RECV;
        default: state <= FR_RECV;
      endcase
    end
  end

  // Reply feed: software bytes then CRC low, CRC high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_idx   <= '0;
      tx_crc   <= mrsc_pkg::CRC_INIT;
      crc_left <= 2'h0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end
    else if (state == FR_HOLD && do_send && online)
    begin
      tx_idx   <= '0;
      tx_crc   <= mrsc_pkg::CRC_INIT;
      crc_left <= 2'h2;
    end
    else if (state == FR_REPLY && online)
    begin
      if (tx_valid)
        tx_valid <= !tx_ready;
      else if (tx_ready && tx_idx != (AW + 1)'(tx_len))
      begin
        tx_data  <= tx_mem[tx_idx[AW-1:0]];
        tx_crc   <= mrsc_pkg::crc16_step(tx_crc, tx_mem[tx_idx[AW-1:0]]);
        tx_idx   <= tx_idx + (AW + 1)'(1);
        tx_valid <= 1'b1;
      end
      else if (tx_ready && crc_left != 2'h0)
      begin
        tx_data  <= (crc_left == 2'h2) ? tx_crc[7:0] : tx_crc[15:8];
        crc_left <= crc_left - 2'h1;
        tx_valid <= 1'b1;
      end
    end
    else
      tx_valid <= 1'b0;
  end

  mrsc_tx u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (cfg),
    .valid   (tx_valid && online),
    .data    (tx_data),
    .ready   (tx_ready),
    .txd     (rs485_tx),
    .de      (rs485_de)
  );

  // AXI4-Lite write channel
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign do_write      = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_reg        = mrsc_pkg::reg_decode(aw_addr);
  assign do_release    = do_write && wr_reg == mrsc_pkg::REG_CTRL && w_strb[1]
                       && w_data[mrsc_pkg::CTRL_RELEASE];
  assign do_send       = do_write && wr_reg == mrsc_pkg::REG_CTRL && w_strb[1]
                       && w_data[mrsc_pkg::CTRL_SEND];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mrsc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == mrsc_pkg::REG_CTRL || wr_reg == mrsc_pkg::REG_TX)
                      ? mrsc_pkg::RESP_OKAY : mrsc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_len <= mrsc_pkg::CTRL_RESET;
    else if (do_write && wr_reg == mrsc_pkg::REG_CTRL && w_strb[0] && state != FR_REPLY)
      tx_len <= (w_data[7:0] > 8'(BUF_DEPTH)) ? 8'(BUF_DEPTH) : w_data[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (do_write && wr_reg == mrsc_pkg::REG_TX && w_strb[0] && state != FR_REPLY)
      tx_mem[aw_addr[AW+1:2]] <= w_data[7:0];
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_reg        = mrsc_pkg::reg_decode(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= mrsc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mrsc_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (rd_reg)
        mrsc_pkg::REG_STATUS:
        begin
          s_axi_rdata[7:0]                   <= station;
          s_axi_rdata[mrsc_pkg::ST_ONLINE]   <= online;
          s_axi_rdata[mrsc_pkg::ST_NONSTD]   <= nonstd;
          s_axi_rdata[mrsc_pkg::ST_READY]    <= (state == FR_HOLD);
          s_axi_rdata[mrsc_pkg::ST_TXBUSY]   <= (state == FR_REPLY);
          s_axi_rdata[mrsc_pkg::ST_PARITY]   <= cfg.parity_en;
          s_axi_rdata[mrsc_pkg::ST_RATE +: 2] <= rate_sw;
          s_axi_rdata[mrsc_pkg::ST_LEN +: 8] <= 8'(frame_len);
        end
        mrsc_pkg::REG_CTRL:  s_axi_rdata[7:0] <= tx_len;
        mrsc_pkg::REG_COUNT: s_axi_rdata <= {cnt_drop, cnt_good};
        mrsc_pkg::REG_RX:    s_axi_rdata[7:0] <= rx_mem[s_axi_araddr[AW+1:2]];
        mrsc_pkg::REG_TX:    s_axi_rdata[7:0] <= tx_mem[s_axi_araddr[AW+1:2]];
        default:             s_axi_rresp <= mrsc_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> common/mrsc_pkg.sv
// Shared constants, types and helpers of the Modbus RTU serial front end
`default_nettype none
package mrsc_pkg;
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          BAUD_R0        = 9600;
  localparam int          BAUD_R1        = 19200;
  localparam int          BAUD_R2        = 38400;
  localparam int          BAUD_R3        = 57600;
  localparam int          FRAME_GAP_BITS = 39;
  localparam int          MIN_FRAME_LEN  = 4;
  localparam int          BUF_DEPTH      = 64;
  localparam logic [7:0]  ADDR_OFFLINE   = 8'h00;
  localparam logic [7:0]  STD_ADDR_MAX   = 8'hF7;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] CRC_GOOD       = 16'h0000;
  localparam logic [11:0] OFS_STATUS     = 12'h000;
  localparam logic [11:0] OFS_CTRL       = 12'h004;
  localparam logic [11:0] OFS_COUNT      = 12'h008;
  localparam logic [11:0] OFS_RX_BASE    = 12'h100;
  localparam logic [11:0] OFS_TX_BASE    = 12'h200;
  localparam logic [11:0] WIN_BYTES      = 12'h100;
  localparam int          CTRL_RELEASE   = 8;
  localparam int          CTRL_SEND      = 9;
  localparam int          ST_ONLINE      = 8;
  localparam int          ST_NONSTD      = 9;
  localparam int          ST_READY       = 10;
  localparam int          ST_TXBUSY      = 11;
  localparam int          ST_PARITY      = 12;
  localparam int          ST_RATE        = 13;
  localparam int          ST_LEN         = 16;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [15:0] bit_cycles;
    logic        parity_en;
  } mrsc_cfg_s;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } mrsc_byte_s;

  typedef enum logic [5:0] {
    REG_STATUS = 6'b000001,
    REG_CTRL   = 6'b000010,
    REG_COUNT  = 6'b000100,
    REG_RX     = 6'b001000,
    REG_TX     = 6'b010000,
    REG_NONE   = 6'b100000
  } mrsc_reg_e;

  function automatic mrsc_reg_e reg_decode(input logic [11:0] a);
    if (a[1:0] != 2'h0) return REG_NONE;
    if (a == OFS_STATUS) return REG_STATUS;
    if (a == OFS_CTRL) return REG_CTRL;
    if (a == OFS_COUNT) return REG_COUNT;
    if (a >= OFS_RX_BASE && a < OFS_RX_BASE + WIN_BYTES) return REG_RX;
    if (a >= OFS_TX_BASE && a < OFS_TX_BASE + WIN_BYTES) return REG_TX;
    return REG_NONE;
  endfunction

  function automatic logic [15:0] bit_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    return 16'(CLK_HZ / BAUD_R0);
      2'h1:    return 16'(CLK_HZ / BAUD_R1);
      2'h2:    return 16'(CLK_HZ / BAUD_R2);
      default: return 16'(CLK_HZ / BAUD_R3);
    endcase
  endfunction

  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/mrsc_rx.sv
// Serial character receiver, 8 data bits, optional even parity
`timescale 1ns/1ps
`default_nettype none
module mrsc_rx (
  input  wire logic                aclk,    // Clock
  input  wire logic                aresetn, // Sync reset, active low
  input  wire mrsc_pkg::mrsc_cfg_s cfg,     // Bit period and parity
  input  wire logic                rxd,     // Line receive data
  output var  mrsc_pkg::mrsc_byte_s rx_byte, // Received character
  output logic                     busy     // Character in progress
);
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } mrsc_rx_e;

  mrsc_rx_e    state;
  logic [15:0] cnt;
  logic [2:0]  bitn;
  logic [7:0]  shreg;
  logic        perr;

  assign busy = (state != RX_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state   <= RX_IDLE;
      cnt     <= 16'h0000;
      bitn    <= 3'h0;
      shreg   <= 8'h00;
      perr    <= 1'b0;
      rx_byte <= '0;
    end
    else
    begin
      rx_byte.valid <= 1'b0;
      if (state != RX_IDLE && cnt != 16'h0000)
        cnt <= cnt - 16'h0001;
      else
      begin
        case (state)
          RX_IDLE:
            if (!rxd)
            begin
              state <= RX_START;
              cnt   <= cfg.bit_cycles >> 1;
              perr  <= 1'b0;
            end
          RX_START:
          begin
            state <= rxd ? RX_IDLE : RX_DATA;
            cnt   <= cfg.bit_cycles - 16'h0001;
            bitn  <= 3'h0;
          end
          RX_DATA:
          begin
            shreg <= {rxd, shreg[7:1]};
            bitn  <= bitn + 3'h1;
            cnt   <= cfg.bit_cycles - 16'h0001;
            if (bitn == 3'h7)
              state <= cfg.parity_en ? RX_PAR : RX_STOP;
          end
          RX_PAR:
          begin
            perr  <= rxd ^ (^shreg);
            cnt   <= cfg.bit_cycles - 16'h0001;
            state <= RX_STOP;
          end
          RX_STOP:
          begin
            // One stop bit checked; a second is plain idle line
            rx_byte.valid <= 1'b1;
            rx_byte.err   <= perr | ~rxd;
            rx_byte.data  <= shreg;
            state         <= RX_IDLE;
          end
          default: state <= RX_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/mrsc_tx.sv
// Serial character transmitter, always eleven bit times per character
`timescale 1ns/1ps
`default_nettype none
module mrsc_tx (
  input  wire logic                aclk,    // Clock
  input  wire logic                aresetn, // Sync reset, active low
  input  wire mrsc_pkg::mrsc_cfg_s cfg,     // Bit period and parity
  input  wire logic                valid,   // Character offered
  input  wire logic [7:0]          data,    // Character to send
  output logic                     ready,   // Takes a character
  output logic                     txd,     // Line transmit data
  output logic                     de       // Line driver enable
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } mrsc_tx_e;

  mrsc_tx_e    state;
  logic [15:0] cnt;
  logic [3:0]  left;
  logic [10:0] sh;

  assign ready = (state == TX_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= TX_IDLE;
      cnt   <= 16'h0000;
      left  <= 4'h0;
      sh    <= 11'h7FF;
      txd   <= 1'b1;
      de    <= 1'b0;
    end
    else
    begin
      case (state)
        TX_IDLE:
          if (valid)
          begin
            // Even parity with one stop, or no parity with two stops
            sh    <= cfg.parity_en ? {1'b1, ^data, data, 1'b0} : {2'b11, data, 1'b0};
            txd   <= 1'b0;
            de    <= 1'b1;
            cnt   <= cfg.bit_cycles - 16'h0001;
            left  <= 4'hA;
            state <= TX_SEND;
          end
        TX_SEND:
          if (cnt != 16'h0000)
            cnt <= cnt - 16'h0001;
          else if (left == 4'h0)
          begin
            de    <= 1'b0;
            txd   <= 1'b1;
            state <= TX_IDLE;
          end
          else
          begin
            sh   <= {1'b1, sh[10:1]};
            txd  <= sh[1];
            left <= left - 4'h1;
            cnt  <= cfg.bit_cycles - 16'h0001;
          end
        default: state <= TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verif/mrsc_top_monitor.sv
// Port-level checker of the serial front end
`timescale 1ns/1ps
`default_nettype none
module mrsc_top_monitor (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, active low
  input wire logic        s_axi_awvalid, // Write address valid
  input wire logic        s_axi_awready, // Write address ready
  input wire logic        s_axi_wvalid,  // Write data valid
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic [11:0] s_axi_araddr,  // Read address
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic [1:0]  s_axi_rresp,   // Read response
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic [7:0]  addr_sw,       // Station switches
  input wire logic [1:0]  rate_sw,       // Rate switches
  input wire logic        parity_sw,     // Parity switch
  input wire logic        rs485_tx,      // Line transmit data
  input wire logic        rs485_de       // Line driver enable
);
  logic [1:0] sw_age;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since a switch last moved
  always_ff @(posedge aclk)
    if (!aresetn || $changed({addr_sw, rate_sw, parity_sw})) sw_age <= 2'h0;
    else if (sw_age != 2'h3) sw_age <= sw_age + 2'h1;
  sequence seq_status_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000 && sw_age == 2'h3;
  endsequence
  sequence seq_zero_held;
    (addr_sw == 8'h00) [*8];
  endsequence
  chk_station_bits: assert property (seq_status_rd |=> s_axi_rdata[7:0] == $past(addr_sw))
    else $error("station field wrong");
  chk_online_bit: assert property (seq_status_rd |=> s_axi_rdata[8] == ($past(addr_sw) != 8'h00))
    else $error("online flag wrong");
  chk_nonstd_bit: assert property (seq_status_rd |=> s_axi_rdata[9] == ($past(addr_sw) > 8'hF7))
    else $error("nonstandard flag wrong");
  chk_cfg_bits: assert property (seq_status_rd |=> s_axi_rdata[14:12] == {$past(rate_sw), $past(parity_sw)})
    else $error("rate or parity field wrong");
  chk_offline_quiet: assert property (seq_zero_held |-> !rs485_de)
    else $error("driver on while off-line");
  chk_idle_high: assert property (!rs485_de |-> rs485_tx)
    else $error("line not idle high");
  chk_start_low: assert property ($rose(rs485_de) |-> ##[0:2] !rs485_tx)
    else $error("no start bit");
  chk_drive_span: assert property ($rose(rs485_de) |=> rs485_de [*8])
    else $error("driver pulse too short");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h00C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
endmodule
bind mrsc_top mrsc_top_monitor u_mon (.*);
`default_nettype wire

// >>> verif/mrsc_master_model.sv
// Bus master model on the shared serial pair
`timescale 1ns/1ps
`default_nettype none
module mrsc_master_model #(
  parameter int BIT = 434
) (
  input  wire logic aclk,     // Clock
  output var  logic line_out, // Request data to the unit
  input  wire logic line_in,  // Reply data from the unit
  input  wire logic de        // Unit drives the line
);
  logic [7:0] rx_q [$];
  initial line_out = 1'b1;
  task automatic wait_bits(input int n);
    repeat (n * BIT) @(posedge aclk);
  endtask
  // One character, low bit first, optional even parity
  task automatic send_char(input logic [7:0] b, input logic par, input int stops);
    line_out <= 1'b0;
    wait_bits(1);
    for (int i = 0; i < 8; i++)
    begin
      line_out <= b[i];
      wait_bits(1);
    end
    if (par)
    begin
      line_out <= ^b;
      wait_bits(1);
    end
    line_out <= 1'b1;
    wait_bits(stops);
  endtask
  // Reply characters sampled mid-bit
  always @(posedge aclk)
    if (de && !line_in)
    begin : rx_char
      logic [7:0] b;
      repeat (BIT / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++)
      begin
        wait_bits(1);
        b[i] = line_in;
      end
      rx_q.push_back(b);
      wait_bits(2);
    end
endmodule
`default_nettype wire

// >>> verif/test_modbus_rtu_switch_config.sv
// Self-checking bench of the serial front end
`timescale 1ns/1ps
`default_nettype none
module test_modbus_rtu_switch_config;
  localparam int         BIT     = 434;
  localparam logic [47:0] CORNERS = 48'hFFF8F7290100;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, parity_sw, rs485_rx, rs485_tx, rs485_de;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rate_sw;
  logic [7:0]  addr_sw;
  int          fail_count = 0;
  int          n_compared = 0;
  mrsc_top dut (.*);
  // Lone unit on the line
  mrsc_master_model #(.BIT(BIT)) m (.aclk(aclk), .line_out(rs485_rx), .line_in(rs485_tx), .de(rs485_de));
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic [31:0] exp_status(input logic [7:0] a, input logic [1:0] t, input logic p);
    return {17'h0, t, p, 2'h0, a > 8'hF7, a != 8'h00, a};
  endfunction
  initial
  begin
    repeat (98000) @(posedge aclk);
    fail_count++;
    finish_test();
  end
  initial
  begin : main
    logic [31:0] d;
    logic [1:0]  r, t;
    logic [7:0]  fr [$];
    logic [7:0]  st, fc, v;
    logic [15:0] c;
    logic        p;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {addr_sw, rate_sw, parity_sw} = 11'h018;
    d = $urandom(92090);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Corner and random switch settings
    for (int i = 0; i < 9; i++)
    begin
      st = (i < 6) ? CORNERS[i * 8 +: 8] : 8'($urandom);
      t = 2'($urandom);
      p = 1'($urandom);
      addr_sw <= st;
      rate_sw <= t;
      parity_sw <= p;
      repeat (4) @(posedge aclk);
      axi_rd(12'h000, d, r);
      check_val(d & 32'h7FFF, exp_status(st, t, p));
    end
    axi_rd(12'h00C, d, r);
    check_val({d[29:0], r}, 32'h2);
    axi_wr(12'h000, 32'hFF, 4'hF, r);
    check_val({30'h0, r}, 32'h2);
    // Own address, no parity, two stops
    st = 8'($urandom_range(247, 1));
    fc = 8'($urandom);
    addr_sw <= st;
    rate_sw <= 2'h3;
    parity_sw <= 1'b0;
    fr = '{st, fc};
    c = crc16(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    repeat (4) @(posedge aclk);
    foreach (fr[i]) m.send_char(fr[i], 1'b0, 2);
    for (int k = 0; k < 400 && d[10] !== 1'b1; k++)
    begin
      repeat (100) @(posedge aclk);
      axi_rd(12'h000, d, r);
    end
    check_val(d & 32'hFF04FF, {16'h0404, st});
    axi_rd(12'h104, d, r);
    check_val(d & 32'hFF, {24'h0, fc});
    axi_rd(12'h008, d, r);
    check_val(d, 32'h1);
    // One byte reply plus its check word
    v = 8'($urandom);
    axi_wr(12'h200, {24'h0, v}, 4'h1, r);
    axi_wr(12'h004, 32'h201, 4'h3, r);
    fr = '{v};
    c = crc16(fr);
    for (int k = 0; k < 20000 && m.rx_q.size() < 3; k++) @(posedge aclk);
    check_val({8'h0, m.rx_q[0], m.rx_q[1], m.rx_q[2]}, {8'h0, v, c[7:0], c[15:8]});
    repeat (3 * BIT) @(posedge aclk);
    axi_rd(12'h000, d, r);
    check_val(d & 32'hC00, 32'h0);
    // Off-line unit, even parity, one stop
    addr_sw <= 8'h00;
    parity_sw <= 1'b1;
    fr = '{8'h00, fc};
    c = crc16(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    repeat (4) @(posedge aclk);
    foreach (fr[i]) m.send_char(fr[i], 1'b1, 1);
    repeat (41 * BIT) @(posedge aclk);
    axi_rd(12'h000, d, r);
    check_val(d & 32'h500, 32'h0);
    axi_rd(12'h008, d, r);
    check_val(d, 32'h10001);
    axi_wr(12'h004, 32'h201, 4'h3, r);
    repeat (11 * BIT) @(posedge aclk);
    check_val(m.rx_q.size(), 32'h3);
    finish_test();
  end
endmodule
`default_nettype wire
